// *** design/direct_mapped_cache.sv ***
// Configurable direct-mapped cache between core local bus and external bus.
`timescale 1ns/100ps
`default_nettype none
`include "cache_consts.svh"
module direct_mapped_cache (
    // Clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset,
    // Organisation control
    input  wire cache_pkg::cache_org_type cache_organisation_control,
    // Core local bus
    input  wire logic                    core_req,
    input  wire logic                    core_we,
    input  wire logic                    core_fetch,
    input  wire logic [31:0]             core_addr,
    input  wire logic [31:0]             core_wdata,
    output logic                         core_ack,
    output logic [31:0]                  core_rdata,
    // External bus
    output logic                         ext_req,
    output logic                         ext_we,
    output logic                         ext_burst,
    output logic [31:0]                  ext_addr,
    output logic [31:0]                  ext_wdata,
    input  wire logic                    ext_ack,
    input  wire logic [31:0]             ext_rdata
);
    import cache_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [`TAG_W-1:0] tag_mem [`LINES];
    logic [31:0]       data_mem [`WORDS];
    logic [`LINES-1:0] valid_r;
    logic [`LINES-1:0] valid_nxt;

    // ------------------------------------------------------------
    // Index selection
    // ------------------------------------------------------------
    logic        cacheable;
    logic [6:0]  line_idx;
    logic [8:0]  word_idx;
    logic        hit;

    always_comb begin
        cacheable = 1'b0;
        line_idx  = core_addr[10:4];
        case (cache_organisation_control)
            org_icache: cacheable = core_fetch;
            org_dcache: cacheable = !core_fetch;
            org_split: begin
                cacheable = 1'b1;
                // Halves keep code and operands from evicting each other.
                line_idx = {!core_fetch, core_addr[9:4]};
            end
            default: cacheable = 1'b0;
        endcase
        word_idx = {line_idx, core_addr[3:2]};
    end

    assign hit = valid_r[line_idx] &&
                 (tag_mem[line_idx] == core_addr[31:11]);

    // ------------------------------------------------------------
    // Control
    // ------------------------------------------------------------
    cache_state_type st_r;
    cache_state_type st_nxt;
    logic        ack_r, ack_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        ereq_r, ereq_nxt;
    logic        ewe_r, ewe_nxt;
    logic        eburst_r, eburst_nxt;
    logic [31:0] eaddr_r, eaddr_nxt;
    logic [31:0] ewdata_r, ewdata_nxt;
    logic        fb_start;
    logic        fb_wr;
    logic [127:0] fb_line;
    logic [2:0]  fb_count;
    logic        fill_done;
    logic        write_hit;

    line_fill_buffer fill_buf (
        .clk   (clk),
        .reset (reset),
        .start (fb_start),
        .wr    (fb_wr),
        .wdata (ext_rdata),
        .line  (fb_line),
        .count (fb_count)
    );

    always_comb begin
        st_nxt     = st_r;
        ack_nxt    = 1'b0;
        rdata_nxt  = rdata_r;
        ereq_nxt   = ereq_r;
        ewe_nxt    = ewe_r;
        eburst_nxt = eburst_r;
        eaddr_nxt  = eaddr_r;
        ewdata_nxt = ewdata_r;
        valid_nxt  = valid_r;
        fb_start   = 1'b0;
        fb_wr      = 1'b0;
        fill_done  = 1'b0;
        write_hit  = 1'b0;
        case (st_r)
            st_idle: begin
                if (core_req && !ack_r) begin
                    if (core_we) begin
                        // Write-through: the external cycle always runs.
                        write_hit  = cacheable && hit;
                        ereq_nxt   = 1'b1;
                        ewe_nxt    = 1'b1;
                        eburst_nxt = 1'b0;
                        eaddr_nxt  = core_addr;
                        ewdata_nxt = core_wdata;
                        st_nxt     = cacheable ? st_write : st_wrun;
                    end else if (cacheable && hit) begin
                        rdata_nxt = data_mem[word_idx];
                        ack_nxt   = 1'b1;
                    end else begin
                        fb_start   = 1'b1;
                        ereq_nxt   = 1'b1;
                        ewe_nxt    = 1'b0;
                        eburst_nxt = cacheable;
                        eaddr_nxt  = cacheable ?
                            {core_addr[31:4], 4'h0} : core_addr;
                        st_nxt     = st_fill;
                    end
                end
            end
            st_fill: begin
                if (ext_ack) begin
                    if (!eburst_r) begin
                        rdata_nxt = ext_rdata;
                        ack_nxt   = 1'b1;
                        ereq_nxt  = 1'b0;
                        st_nxt    = st_idle;
                    end else begin
                        fb_wr = 1'b1;
                        if (fb_count[1:0] == core_addr[3:2]) begin
                            rdata_nxt = ext_rdata;
                        end
                        eaddr_nxt = {eaddr_r[31:4],
                            eaddr_r[3:2] + 2'h1, 2'h0};
                        if (fb_count == 3'(`LINE_WORDS - 1)) begin
                            fill_done = 1'b1;
                            valid_nxt[line_idx] = 1'b1;
                            ereq_nxt   = 1'b0;
                            eburst_nxt = 1'b0;
                            ack_nxt    = 1'b1;
                            st_nxt     = st_idle;
                        end
                    end
                end
            end
            st_write, st_wrun: begin
                if (ext_ack) begin
                    ereq_nxt = 1'b0;
                    ewe_nxt  = 1'b0;
                    ack_nxt  = 1'b1;
                    st_nxt   = st_idle;
                end
            end
            default: st_nxt = st_idle;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            st_r     <= st_idle;
            ack_r    <= 1'b0;
            rdata_r  <= 32'h0;
            ereq_r   <= 1'b0;
            ewe_r    <= 1'b0;
            eburst_r <= 1'b0;
            eaddr_r  <= 32'h0;
            ewdata_r <= 32'h0;
            valid_r  <= '0;
        end else begin
            st_r     <= st_nxt;
            ack_r    <= ack_nxt;
            rdata_r  <= rdata_nxt;
            ereq_r   <= ereq_nxt;
            ewe_r    <= ewe_nxt;
            eburst_r <= eburst_nxt;
            eaddr_r  <= eaddr_nxt;
            ewdata_r <= ewdata_nxt;
            valid_r  <= valid_nxt;
        end
    end

    // Arrays carry no reset; valid bits alone guard them.
    always_ff @(posedge clk) begin
        if (fill_done) begin
            tag_mem[line_idx] <= core_addr[31:11];
            data_mem[{line_idx, 2'h0}] <= fb_line[31:0];
            data_mem[{line_idx, 2'h1}] <= fb_line[63:32];
            data_mem[{line_idx, 2'h2}] <= fb_line[95:64];
            data_mem[{line_idx, 2'h3}] <= ext_rdata;
        end else if (write_hit) begin
            data_mem[word_idx] <= core_wdata;
        end
    end

    assign core_ack   = ack_r;
    assign core_rdata = rdata_r;
    assign ext_req    = ereq_r;
    assign ext_we     = ewe_r;
    assign ext_burst  = eburst_r;
    assign ext_addr   = eaddr_r;
    assign ext_wdata  = ewdata_r;
endmodule
`default_nettype wire

// *** design/line_fill_buffer.sv ***
// Line fill buffer holding one 16-byte line during miss processing.
`timescale 1ns/100ps
`default_nettype none
`include "cache_consts.svh"
module line_fill_buffer (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // Fill side
    input  wire logic        start,
    input  wire logic        wr,
    input  wire logic [31:0] wdata,
    // Contents
    output logic [127:0]     line,
    output logic [2:0]       count
);
    logic [127:0] line_r;
    logic [127:0] line_nxt;
    logic [2:0]   cnt_r;
    logic [2:0]   cnt_nxt;

    always_comb begin
        line_nxt = line_r;
        cnt_nxt  = cnt_r;
        if (start) begin
            cnt_nxt = 3'h0;
        end else if (wr) begin
            line_nxt[cnt_r[1:0]*32 +: 32] = wdata;
            cnt_nxt = cnt_r + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            line_r <= 128'h0;
            cnt_r  <= 3'h0;
        end else begin
            line_r <= line_nxt;
            cnt_r  <= cnt_nxt;
        end
    end

    assign line  = line_r;
    assign count = cnt_r;
endmodule
`default_nettype wire

// *** inc/cache_consts.svh ***
// Constants for the configurable direct-mapped cache.
// Notes on behaviour
// - Data-only: tag index is address 10:4, data index is address 10:2.
// - Split fetches: index top bit zero, address 9:4 below it.
// - Split operand accesses: index top bit one, address 9:4 below it.
// - Tag hit drives array data onto the core bus in one cycle.
// - Read tag miss fetches the whole 16-byte line from memory behind the cache; a write miss fetches nothing.
// - Miss data is held in a 16-byte line fill buffer; the last word goes into the array straight from the bus.
// - Data configurations write through: every operand write goes external.
// - Instruction-only: tag index is address 10:4, data index 10:2.
// - Direct-mapped, 128 lines of 16 bytes, 512 by 32 data array.
`ifndef CACHE_CONSTS_SVH
`define CACHE_CONSTS_SVH
`define LINES        128
`define WORDS        512
`define LINE_WORDS   4
`define TAG_W        21
`define ORG_ICACHE   2'h0
`define ORG_DCACHE   2'h1
`define ORG_SPLIT    2'h2
`endif

// *** inc/cache_pkg.sv ***
// Types shared by the cache design.
package cache_pkg;
    typedef enum logic [1:0] {
        org_icache,
        org_dcache,
        org_split,
        org_none
    } cache_org_type;
    typedef enum {
        st_idle,
        st_fill,
        st_write,
        st_wrun
    } cache_state_type;
endpackage

// *** sim/direct_mapped_cache_asserts.sv ***
// Port checker for the direct-mapped cache.
`timescale 1ns/100ps
`default_nettype none
module cache_checker (
    input wire logic                     clk,
    input wire logic                     reset,
    input wire cache_pkg::cache_org_type cache_organisation_control,
    input wire logic                     core_req,
    input wire logic                     core_we,
    input wire logic                     core_fetch,
    input wire logic [31:0]              core_addr,
    input wire logic [31:0]              core_wdata,
    input wire logic                     core_ack,
    input wire logic                     ext_req,
    input wire logic                     ext_we,
    input wire logic                     ext_burst,
    input wire logic [31:0]              ext_addr,
    input wire logic [31:0]              ext_wdata,
    input wire logic                     ext_ack
);
    import cache_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    sequence fill_word;
        ext_req && ext_burst && ext_ack;
    endsequence
    sequence op_write;
        $rose(core_req) && core_we && !core_fetch &&
            cache_organisation_control inside {org_dcache, org_split};
    endsequence
    a_write_through: assert property (op_write |=> ext_req && ext_we &&
        ext_addr == $past(core_addr) && ext_wdata == $past(core_wdata))
        else $error("operand write did not go out");
    a_fill_align: assert property ($rose(ext_req) && ext_burst |->
        ext_addr[3:0] == 4'h0 && !ext_we) else $error("fill not line based");
    a_fill_step: assert property (fill_word ##0 ext_addr[3:2] != 2'h3 |=>
        ext_req && ext_addr == $past(ext_addr) + 32'h4)
        else $error("fill did not step");
    a_fill_done: assert property (fill_word ##0 ext_addr[3:2] == 2'h3 |=>
        !ext_req && core_ack) else $error("fill did not end");
    a_single_done: assert property (ext_req && !ext_burst && ext_ack |=>
        !ext_req && core_ack) else $error("single cycle did not end");
    a_ack_pulse: assert property (core_ack |=> !core_ack)
        else $error("ack longer than a cycle");
    a_ack_cause: assert property (core_ack |-> $past(core_req))
        else $error("ack without request");
    a_req_stands: assert property (ext_req && !ext_ack |=> ext_req &&
        $stable(ext_addr) && $stable(ext_burst)) else $error("bus moved");
    a_hit_or_fill: assert property ($rose(core_req) && !core_we |=>
        core_ack || ext_req) else $error("read neither hit nor went out");
endmodule
bind direct_mapped_cache cache_checker u_chk (.clk, .reset,
    .cache_organisation_control, .core_req, .core_we, .core_fetch,
    .core_addr, .core_wdata, .core_ack, .ext_req, .ext_we, .ext_burst,
    .ext_addr, .ext_wdata, .ext_ack);
`default_nettype wire

// *** sim/ext_memory_model.sv ***
// Behavioural external memory answering the cache's external bus.
`timescale 1ns/100ps
`default_nettype none
module ext_memory_model (
    // Clock
    input  wire logic        clk,
    // External bus
    input  wire logic        ext_req,
    input  wire logic [31:0] ext_addr,
    input  wire logic [1:0]  slow,
    output logic             ext_ack,
    output logic [31:0]      ext_rdata
);
    logic [1:0] waited = 2'h0;
    initial ext_ack = 1'b0;
    initial ext_rdata = 32'h0;
    // Data toggles outside the ack cycle so stale data never looks valid.
    always @(negedge clk) begin
        if (ext_req && !ext_ack && waited >= slow) begin
            ext_ack <= 1'b1;
            ext_rdata <= ext_addr ^ 32'h5a5a_0000;
            waited <= 2'h0;
        end else begin
            ext_ack <= 1'b0;
            ext_rdata <= ~ext_rdata;
            waited <= waited + {1'b0, ext_req};
        end
    end
endmodule
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the direct-mapped cache.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import cache_pkg::*;
    localparam logic [31:0] A = 32'h0001_2350;
    logic          clk = 1'b0;
    logic          reset = 1'b1;
    cache_org_type org = org_dcache;
    logic          core_req = 1'b0;
    logic          core_we = 1'b0;
    logic          core_fetch = 1'b0;
    logic [31:0]   core_addr = 32'h0;
    logic [31:0]   core_wdata = 32'h0;
    logic [1:0]    slow = 2'h0;
    logic          core_ack, ext_req, ext_we, ext_burst, ext_ack;
    logic [31:0]   core_rdata, ext_addr, ext_wdata, ext_rdata;
    int            fails = 0;
    int            comparisons = 0;
    int            bursts = 0;
    int            wrs = 0;
    always #50 clk = ~clk;
    always @(posedge clk) begin
        if (ext_req && ext_ack && ext_we) wrs++;
        if (ext_req && ext_ack && ext_burst && ext_addr[3:2] == 2'h3) bursts++;
    end
    direct_mapped_cache u_dut (.clk, .reset,
        .cache_organisation_control(org), .core_req, .core_we, .core_fetch,
        .core_addr, .core_wdata, .core_ack, .core_rdata, .ext_req, .ext_we,
        .ext_burst, .ext_addr, .ext_wdata, .ext_ack, .ext_rdata);
    ext_memory_model u_mem (.clk, .ext_req, .ext_addr, .slow, .ext_ack,
        .ext_rdata);
    function automatic logic [31:0] mem(input logic [31:0] a);
        return a ^ 32'h5a5a_0000;
    endfunction
    task automatic chk(input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One access; e is the write data or the expected read data.
    task automatic acc(input logic f, w, input logic [31:0] a, e,
                       input int hit, nb, nw);
        int b0 = bursts;
        int w0 = wrs;
        int n = 0;
        core_fetch = f;
        core_we = w;
        core_addr = a;
        core_wdata = e;
        core_req = 1'b1;
        while (core_ack !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        core_req = 1'b0;
        if (!w) chk(core_rdata, e);
        // A hit answers one cycle after the take, so one falling edge.
        chk(32'(n == 1), 32'(hit));
        chk(32'(bursts - b0), 32'(nb));
        chk(32'(wrs - w0), 32'(nw));
        @(negedge clk);
    endtask
    task automatic restart(input cache_org_type o);
        reset = 1'b1;
        org = o;
        repeat (5) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        #1_000_000;
        fails++;
        tally_and_finish();
    end
    task automatic test_data_cache;
        restart(org_dcache);
        acc(0, 0, A, mem(A), 0, 1, 0);
        acc(0, 0, A + 32'hc, mem(A + 32'hc), 1, 0, 0);
        acc(0, 0, A ^ 32'h400, mem(A ^ 32'h400), 0, 1, 0);
        // Bit 10 selects another line, so the first line must survive.
        acc(0, 0, A + 32'h4, mem(A + 32'h4), 1, 0, 0);
        acc(0, 0, A + 32'h800, mem(A + 32'h800), 0, 1, 0);
        acc(0, 0, A, mem(A), 0, 1, 0);
        acc(0, 1, A + 32'h8, 32'h1234_5678, 0, 0, 1);
        acc(0, 0, A + 32'h8, 32'h1234_5678, 1, 0, 0);
        $display("data cache test done");
    endtask
    task automatic test_instr_cache;
        restart(org_icache);
        slow = 2'h2;
        acc(1, 0, A, mem(A), 0, 1, 0);
        acc(1, 0, A ^ 32'h400, mem(A ^ 32'h400), 0, 1, 0);
        acc(1, 0, A + 32'h4, mem(A + 32'h4), 1, 0, 0);
        slow = 2'h0;
        $display("instruction cache test done");
    endtask
    task automatic test_split_cache;
        restart(org_split);
        acc(1, 0, A, mem(A), 0, 1, 0);
        acc(0, 0, A, mem(A), 0, 1, 0);
        acc(1, 0, A + 32'h800, mem(A + 32'h800), 0, 1, 0);
        acc(0, 0, A, mem(A), 1, 0, 0);
        acc(1, 0, A, mem(A), 0, 1, 0);
        acc(0, 1, A, 32'h0bad_f00d, 0, 0, 1);
        $display("split cache test done");
    endtask
    initial begin
        test_data_cache();
        test_instr_cache();
        test_split_cache();
        tally_and_finish();
    end
endmodule
`default_nettype wire
